// file: hdl/backlight_timeout_fade_sequencer.sv
// Backlight dim/off timeout sequencer with proportional fade of the target current level.
//
// How it works
// - Off delay elapsed and nonzero: switch off.
// - Off delay counts after dim delay, or from maximum when dim is disabled.
// - Off field zero disables; N means N seconds.
// - Dim delay elapsed and nonzero: go dim.
// - Dim delay starts once maximum is reached.
// - Dim field zero disables; N means N seconds.
// - Fade-down code zero: change level immediately.
// - Nonzero fade-down: ramp gradually to dim/off.
// - Fade time spans full scale 30 to 0.
// - Smaller steps finish in proportionally less time.
// - Rate codes step in 0.3 second increments up to code A, then 0.5 second.
// - Turn-on ramps up to maximum, zero immediate.
module backlight_timeout_fade_sequencer #(
  parameter int CYC_PER_MS = bl_seq_pkg::CYC_PER_MS_DOC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire bl_seq_pkg::reg_req_t reg_req,
  input wire logic [7:0] rd_addr,
  input wire logic backlight_on,
  input wire logic [bl_seq_pkg::LEVEL_W-1:0] dim_level,
  output logic [7:0] rd_data,
  output logic [bl_seq_pkg::LEVEL_W-1:0] level,
  output bl_seq_pkg::phase_t phase
);
  import bl_seq_pkg::*;

  localparam logic [31:0] TICK_CYC = 32'(TICK_MS * CYC_PER_MS);

  typedef struct packed
  {
    phase_t phase;
    logic [LEVEL_W-1:0] level;
    logic [LEVEL_W-1:0] target;
    logic [6:0] secs;
    logic [31:0] tick_cnt;
    logic [31:0] step_cnt;
    logic was_on;
    logic [6:0] off_delay_secs;
    logic [6:0] dim_delay_secs;
    logic [3:0] fade_down_rate;
    logic [3:0] fade_up_rate;
    logic [7:0] rd_data;
  } state_t;

  state_t cur;
  state_t next_cur;

  // Cycles per level code so a full-scale swing takes the programmed time.
  // A smaller swing needs fewer steps at the same rate, so it ends proportionally sooner.
  function automatic logic [31:0] step_cycles(input logic [3:0] code);
    logic [63:0] cyc;
    cyc = 64'(fade_ms(code)) * 64'(CYC_PER_MS) / 64'(LEVEL_FULL);
    return (cyc == 64'h0) ? 32'h1 : cyc[31:0];
  endfunction

  // Register read mux; reserved bit 7 of the delay registers reads zero.
  function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == OFF_DELAY_ADDR)
      d = {1'b0, s.off_delay_secs};
    else if (a == DIM_DELAY_ADDR)
      d = {1'b0, s.dim_delay_secs};
    else if (a == FADE_RATES_ADDR)
      d = {s.fade_down_rate, s.fade_up_rate};
    return d;
  endfunction

  // Strobes of this cycle, decoded once and shared by the fade and sequencing logic.
  logic tick;
  logic step_due;
  logic turn_on;

  // Next state of the whole block.
  always_comb
  begin
    next_cur = cur;
    tick = (cur.tick_cnt == TICK_CYC - 32'h1);
    step_due = 1'b0;
    turn_on = backlight_on && !cur.was_on;
    next_cur.was_on = backlight_on;
    next_cur.rd_data = read_reg(cur, rd_addr);
    if (reg_req.wr)
    begin
      if (reg_req.addr == OFF_DELAY_ADDR)
        next_cur.off_delay_secs = reg_req.wdata[DELAY_MSB:0];
      if (reg_req.addr == DIM_DELAY_ADDR)
        next_cur.dim_delay_secs = reg_req.wdata[DELAY_MSB:0];
      if (reg_req.addr == FADE_RATES_ADDR)
      begin
        next_cur.fade_down_rate = reg_req.wdata[FADE_DOWN_MSB:FADE_DOWN_LSB];
        next_cur.fade_up_rate = reg_req.wdata[FADE_UP_MSB:FADE_UP_LSB];
      end
    end
    // Second counter runs only in the two waiting phases.
    if (cur.phase == ST_MAX || cur.phase == ST_DIM)
    begin
      next_cur.tick_cnt = tick ? 32'h0 : cur.tick_cnt + 32'h1;
      if (tick)
        next_cur.secs = cur.secs + 7'h1;
    end
    unique case (cur.phase)
      ST_OFF, ST_DIM, ST_MAX:
        next_cur.step_cnt = 32'h0;
      ST_RISE:
      begin
        step_due = (cur.fade_up_rate == FADE_OFF_CODE) ||
          (cur.step_cnt >= step_cycles(cur.fade_up_rate) - 32'h1);
        next_cur.step_cnt = step_due ? 32'h0 : cur.step_cnt + 32'h1;
      end
      ST_FALL:
      begin
        step_due = (cur.fade_down_rate == FADE_OFF_CODE) ||
          (cur.step_cnt >= step_cycles(cur.fade_down_rate) - 32'h1);
        next_cur.step_cnt = step_due ? 32'h0 : cur.step_cnt + 32'h1;
      end
    endcase
    // Sequencing; a fresh turn-on always restarts, and a turn-off fades to zero.
    if (turn_on)
    begin
      next_cur.phase = ST_RISE;
      next_cur.step_cnt = 32'h0;
    end
    else if (!backlight_on && cur.phase != ST_OFF &&
      !(cur.phase == ST_FALL && cur.target == LEVEL_ZERO))
    begin
      next_cur.phase = ST_FALL;
      next_cur.target = LEVEL_ZERO;
      next_cur.step_cnt = 32'h0;
    end
    else
    begin
      unique case (cur.phase)
        ST_OFF:
          next_cur.level = LEVEL_ZERO;
        ST_RISE:
        begin
          if (cur.fade_up_rate == FADE_OFF_CODE)
            next_cur.level = LEVEL_FULL;
          else if (step_due && cur.level != LEVEL_FULL)
            next_cur.level = cur.level + 7'h1;
          if (next_cur.level == LEVEL_FULL)
          begin
            next_cur.phase = ST_MAX;
            next_cur.secs = 7'h0;
            next_cur.tick_cnt = 32'h0;
          end
        end
        ST_MAX:
        begin
          if (cur.dim_delay_secs != DELAY_DISABLED)
          begin
            if (tick && next_cur.secs == cur.dim_delay_secs)
            begin
              next_cur.phase = ST_FALL;
              next_cur.target = dim_level;
            end
          end
          else if (cur.off_delay_secs != DELAY_DISABLED && tick &&
            next_cur.secs == cur.off_delay_secs)
          begin
            next_cur.phase = ST_FALL;
            next_cur.target = LEVEL_ZERO;
          end
        end
        ST_DIM:
        begin
          if (cur.off_delay_secs != DELAY_DISABLED && tick &&
            next_cur.secs == cur.off_delay_secs)
          begin
            next_cur.phase = ST_FALL;
            next_cur.target = LEVEL_ZERO;
          end
        end
        ST_FALL:
        begin
          if (cur.fade_down_rate == FADE_OFF_CODE)
            next_cur.level = cur.target;
          else if (step_due && cur.level > cur.target)
            next_cur.level = cur.level - 7'h1;
          else if (step_due && cur.level < cur.target)
            next_cur.level = cur.target;
          if (next_cur.level == cur.target)
          begin
            // Off delay starts only now, after the dim fade has settled.
            next_cur.phase = (cur.target == LEVEL_ZERO) ? ST_OFF : ST_DIM;
            next_cur.secs = 7'h0;
            next_cur.tick_cnt = 32'h0;
          end
        end
      endcase
    end
  end

  // State register; the delay fields reset to zero so no timeout runs by surprise.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.phase <= ST_OFF;
      cur.off_delay_secs <= REG_RESET[DELAY_MSB:0];
      cur.dim_delay_secs <= REG_RESET[DELAY_MSB:0];
      cur.fade_down_rate <= REG_RESET[FADE_DOWN_MSB:FADE_DOWN_LSB];
      cur.fade_up_rate <= REG_RESET[FADE_UP_MSB:FADE_UP_LSB];
    end
    else
      cur <= next_cur;
  end

  // Every output is a field of the state register, so no input reaches a pin without a flip-flop.
  assign rd_data = cur.rd_data;
  assign level = cur.level;
  assign phase = cur.phase;
endmodule

// file: hdl/bl_seq_pkg.sv
// Package with register map, field layout, timing constants and shared types of the backlight sequencer.
package bl_seq_pkg;
  // Register offsets.
  localparam logic [7:0] OFF_DELAY_ADDR = 8'h06;
  localparam logic [7:0] DIM_DELAY_ADDR = 8'h07;
  localparam logic [7:0] FADE_RATES_ADDR = 8'h08;
  // Register reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions.
  localparam int DELAY_MSB = 6;
  localparam int FADE_DOWN_MSB = 7;
  localparam int FADE_DOWN_LSB = 4;
  localparam int FADE_UP_MSB = 3;
  localparam int FADE_UP_LSB = 0;
  localparam logic [3:0] FADE_OFF_CODE = 4'h0;
  localparam logic [6:0] DELAY_DISABLED = 7'h00;
  // Timing: clock period, one millisecond and the delay tick, each in its own unit.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_IN_PS = 1000000000;
  localparam int TICK_MS = 1000;
  localparam int CYC_PER_MS_DOC = MS_IN_PS / CLK_PERIOD_PS;
  // Current level code: full scale code stands for 30 mA, zero for 0 mA.
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 7'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 7'h7F;

  typedef enum logic [2:0]
  {
    ST_OFF = 3'b000,
    ST_RISE = 3'b001,
    ST_MAX = 3'b010,
    ST_DIM = 3'b011,
    ST_FALL = 3'b100
  } phase_t;

  typedef struct packed
  {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Full-scale fade duration in milliseconds for a rate code.
  function automatic int fade_ms(input logic [3:0] code);
    int ms;
    ms = 100;
    unique case (code)
      4'h0: ms = 100;
      4'h1: ms = 300;
      4'h2: ms = 600;
      4'h3: ms = 900;
      4'h4: ms = 1200;
      4'h5: ms = 1500;
      4'h6: ms = 1800;
      4'h7: ms = 2100;
      4'h8: ms = 2400;
      4'h9: ms = 2700;
      4'hA: ms = 3000;
      4'hB: ms = 3500;
      4'hC: ms = 4000;
      4'hD: ms = 4500;
      4'hE: ms = 5000;
      4'hF: ms = 5500;
    endcase
    return ms;
  endfunction
endpackage

// file: tb/bl_seq_assertions.sv
// Port checker of the backlight sequencer.
module bl_seq_assertions
#(
  parameter int CYC_PER_MS = 1
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] rd_addr,
  input wire logic backlight_on,
  input wire logic [6:0] dim_level,
  input wire logic [7:0] rd_data,
  input wire logic [6:0] level,
  input wire bl_seq_pkg::phase_t phase
);
  timeunit 1ns;
  timeprecision 1ps;
  import bl_seq_pkg::*;
  localparam int TICK = TICK_MS * CYC_PER_MS;
  logic [19:0] max_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles spent at maximum, so an early timeout cannot slip by.
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      max_cnt <= '0;
    else
      max_cnt <= (phase == ST_MAX) ? max_cnt + 20'h1 : '0;
  sequence s_leave_max; phase == ST_MAX && backlight_on ##1 phase == ST_FALL; endsequence
  sequence s_fall_dim; phase == ST_FALL ##1 phase == ST_DIM; endsequence
  sequence s_stay_dim; phase == ST_DIM ##1 phase == ST_DIM; endsequence
  sequence s_stay_fall; phase == ST_FALL ##1 phase == ST_FALL; endsequence
  property p_start; $rose(backlight_on) |=> phase == ST_RISE; endproperty
  property p_max; phase == ST_MAX |-> level == LEVEL_FULL; endproperty
  property p_off; phase == ST_OFF |-> level == LEVEL_ZERO; endproperty
  property p_wait; s_leave_max |-> $past(max_cnt) + 2 >= TICK; endproperty
  property p_dim; s_fall_dim |-> level == dim_level; endproperty
  property p_hold; s_stay_dim |-> $stable(level); endproperty
  property p_down; s_stay_fall |-> level <= $past(level); endproperty
  property p_resv; rd_addr == OFF_DELAY_ADDR || rd_addr == DIM_DELAY_ADDR |=> !rd_data[7]; endproperty
  a_start: assert property (p_start) else $error("no rise after enable");
  a_max: assert property (p_max) else $error("maximum phase below full");
  a_off: assert property (p_off) else $error("off phase with current");
  a_wait: assert property (p_wait) else $error("timeout too early");
  a_dim: assert property (p_dim) else $error("dim level wrong");
  a_hold: assert property (p_hold) else $error("dim level moved");
  a_down: assert property (p_down) else $error("fade went up");
  a_resv: assert property (p_resv) else $error("reserved bit set");
endmodule

// file: tb/led_sink_model.sv
// Model of the LED current sinks following the target level.
module led_sink_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [6:0] level,
  output logic [6:0] peak
);
  timeunit 1ns;
  timeprecision 1ps;
  // Highest current drawn since the LEDs were last dark, so every sequence shows its own full-scale peak.
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      peak <= 7'h00;
    else if (level == 7'h00)
      peak <= 7'h00;
    else if (level > peak)
      peak <= level;
endmodule

// file: tb/backlight_timeout_fade_sequencer_tb.sv
// Self-checking bench of the backlight sequencer.
module backlight_timeout_fade_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bl_seq_pkg::*;
  localparam int CPM = 1;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic backlight_on = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] rd_data;
  logic [6:0] dim_level = 7'h40;
  logic [6:0] level;
  logic [6:0] peak;
  phase_t phase;
  int fails = 0;
  int check_count = 0;
  int n;
  backlight_timeout_fade_sequencer #(.CYC_PER_MS(CPM)) uut (.clk_sys, .rst, .reg_req, .rd_addr, .backlight_on,
    .dim_level, .rd_data, .level, .phase);
  led_sink_model sink (.clk_sys, .rst, .level, .peak);
  // Free-running 4 ns clock.
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // A few cycles of slack cover the pipeline of the phase register.
  task automatic cmp_time(input int got, input int exp);
    check_count++;
    if (got < exp - 3 || got > exp + 3)
    begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req <= '{1'b1, a, d};
    @(negedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    rd_addr <= a;
    @(negedge clk_sys);
    cmp(rd_data, exp);
  endtask
  task automatic wait_phase(input phase_t p, input int exp);
    n = 0;
    while (phase !== p && n < 20000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000)
    begin
      fails++;
      report_and_stop();
    end
    cmp_time(n, exp);
  endtask
  // One full on, dim, off sequence with both fade codes set to k; full-scale time grows 300 ms a code up to A,
  // then 500 ms a code.
  task automatic run(input logic [3:0] k);
    int ms;
    int s;
    ms = (k > 4'hA) ? 3000 + 500 * (k - 4'hA) : 300 * k;
    s = ms * CPM / 127;
    wr(FADE_RATES_ADDR, {k, k});
    @(negedge clk_sys);
    backlight_on <= 1'b1;
    wait_phase(ST_MAX, (k == 4'h0) ? 2 : 1 + 127 * s);
    wait_phase(ST_FALL, 1000 * CPM);
    cmp({1'b0, peak}, 8'h7F);
    wait_phase(ST_DIM, (k == 4'h0) ? 1 : 63 * s);
    cmp({1'b0, level}, 8'h40);
    wait_phase(ST_FALL, 1000 * CPM);
    wait_phase(ST_OFF, (k == 4'h0) ? 1 : 64 * s);
    backlight_on <= 1'b0;
    $display("sequence with rate code %0h done", k);
  endtask
  // Main sequence: registers, rate codes of both step sizes, then disabled and off-only delays.
  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst <= 1'b0;
    rd(FADE_RATES_ADDR, 8'h00);
    wr(OFF_DELAY_ADDR, 8'hFF);
    wr(DIM_DELAY_ADDR, 8'h81);
    rd(OFF_DELAY_ADDR, 8'h7F);
    rd(DIM_DELAY_ADDR, 8'h01);
    rd(8'h09, 8'h00);
    wr(OFF_DELAY_ADDR, 8'h01);
    $display("register test done");
    for (int k = 0; k < 5; k++)
      run(k[3:0]);
    run(4'hB);
    run(4'hF);
    wr(OFF_DELAY_ADDR, 8'h00);
    wr(DIM_DELAY_ADDR, 8'h00);
    wr(FADE_RATES_ADDR, 8'h00);
    backlight_on <= 1'b1;
    wait_phase(ST_MAX, 2);
    repeat (1500) @(negedge clk_sys);
    cmp({5'h00, phase}, {5'h00, ST_MAX});
    backlight_on <= 1'b0;
    wait_phase(ST_OFF, 2);
    wr(OFF_DELAY_ADDR, 8'h02);
    backlight_on <= 1'b1;
    wait_phase(ST_MAX, 2);
    wait_phase(ST_FALL, 2000 * CPM);
    wait_phase(ST_OFF, 1);
    $display("timeout test done");
    report_and_stop();
  end
endmodule
bind backlight_timeout_fade_sequencer bl_seq_assertions #(.CYC_PER_MS(CYC_PER_MS)) chk (.clk_sys, .rst, .rd_addr,
  .backlight_on, .dim_level, .rd_data, .level, .phase);
